// File: rtl/spc_consts.vh
// Constants for the stall prevention control block.
// Assumes a 20 MHz hclk and a 32-bit AHB-Lite register port.
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// Clock and timing
`define SPC_CLK_NS        50
`define SPC_TICK_MS       100
`define SPC_TICK_CYC      (`SPC_TICK_MS * 1000000 / `SPC_CLK_NS)
`define SPC_TRIP_MS       3000
`define SPC_TRIP_TICKS    (`SPC_TRIP_MS / `SPC_TICK_MS)
`define SPC_HOLD_TICKS    2

// Register byte offsets
`define SPC_OFS_LEVEL     8'h00
`define SPC_OFS_HSFACT    8'h04
`define SPC_OFS_REDFREQ   8'h08
`define SPC_OFS_LEVEL2    8'h0C
`define SPC_OFS_MODE      8'h10
`define SPC_OFS_DELAY     8'h14
`define SPC_OFS_STATUS    8'h18
`define SPC_OFS_CLEAR     8'h1C
`define SPC_OFS_INFUNC    8'h20
`define SPC_OFS_OUTFUNC   8'h40

// Reset values
`define SPC_RST_LEVEL     16'h05DC
`define SPC_RST_HSFACT    16'h270F
`define SPC_RST_REDFREQ   16'h1770
`define SPC_RST_LEVEL2    16'h270F
`define SPC_RST_MODE      8'h00
`define SPC_RST_DELAY     16'h0000

// Special codes
`define SPC_NOT_USED      16'h270F
`define SPC_FUNC_FLAG_POS 8'h03
`define SPC_FUNC_FLAG_NEG 8'h67
`define SPC_FUNC_SECOND   8'h03
`define SPC_MODE_ALL      8'h64
`define SPC_MODE_NOFAST   8'h65
`define SPC_FREQ_1HZ      16'h0064
`define SPC_FREQ_400HZ    16'h9C40
`define SPC_PCT_100       16'h0064

// Operating phase codes
`define SPC_PH_CONST      2'h0
`define SPC_PH_ACCEL      2'h1
`define SPC_PH_DECEL      2'h2

// Frequency steering codes
`define SPC_FC_NONE       2'h0
`define SPC_FC_RAISE      2'h1
`define SPC_FC_LOWER      2'h2

`endif

// File: rtl/spc_stall_ctrl.v
// Stall prevention control with an AHB-Lite register port.
// Assumes current and frequency samples synchronous to hclk, one master.
//
// Overview of operation
// RL1: Engage when current exceeds stall level.
// RL2: Accel lowers, constant lowers, decel raises frequency.
// RL3: Flag held over 100 ms, drops below level.
// RL4: Delay 0 immediate, 0.1-25 s, 9999 never.
// RL5: Terminal code 3 positive, 103 negative flag.
// RL6: Frequency at 1 Hz for 3 s trips.
// RL7: Reduced level above start frequency by formula.
// RL8: Factor 9999 keeps level constant to 400 Hz.
// RL9: Operator sets 60 Hz and 100 percent.
// RL10: Second set selects second stall level.
// RL11: Second set from input function code 3.
// RL12: Second set enables all second functions.
// RL13: Mode bits gate fast limit and phases.
// RL14: Stop mode raises fault at flag time.
// RL15: Modes 100 and 101 split drive, regen.
// RL16: Fast current limit never raises flag.
// RL17: All phases disabled gives no flag, trip.
// RL18: Delay timer restarts when current recovers.
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "spc_consts.vh"

module spc_stall_ctrl #(
  parameter TICK_CYC = `SPC_TICK_CYC, // Cycles per 100 ms tick
  parameter N_IN     = 5,             // Input terminals
  parameter N_OUT    = 3              // Output terminals
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg               hreadyout,
  output reg  [31:0]       hrdata,
  output reg               hresp,
  // Drive measurements
  input  wire [15:0]       out_current,    // 0.1 % of rated
  input  wire [15:0]       out_freq,       // 0.01 Hz
  input  wire [1:0]        drive_phase,
  input  wire              regen,
  input  wire              fast_over,      // Fast limit comparator
  // Terminals
  input  wire [N_IN-1:0]   in_term,
  output reg  [N_OUT-1:0]  out_term,
  // Drive control
  output reg  [1:0]        freq_cmd,
  output reg               stall_active_flag,
  output reg               stall_frequency_trip,
  output reg               stall_stop_fault,
  output reg               fast_limit_off,
  output reg               output_shutoff,
  output reg               second_set_select
);

  ////////////////////////////////////////////////////////////////////
  // Mode decode: {stop_on_flag, no_decel, no_const, no_accel, no_fast}
  function [4:0] mode_dec;
    input [7:0] m;
    input       rg;
    begin
      if (m == `SPC_MODE_ALL)
        mode_dec = 5'h00; // RL15
      else if (m == `SPC_MODE_NOFAST)
        mode_dec = rg ? 5'h00 : 5'h01; // RL15
      else if (m < 8'h20)
        mode_dec = m[4:0]; // RL13
      else
        mode_dec = 5'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  reg  [15:0] level_r;         // stall_level_pct
  reg  [15:0] hsfact_r;        // high_speed_level_factor
  reg  [15:0] redfreq_r;       // level_reduction_start_freq
  reg  [15:0] level2_r;        // second_stall_level
  reg  [7:0]  mode_r;          // stall_mode_select
  reg  [15:0] delay_r;         // stall_flag_delay, 0.1 s units
  reg  [7:0]  infunc_r [0:N_IN-1];
  reg  [7:0]  outfunc_r [0:N_OUT-1];
  // Bus pipeline
  reg         wr_pend_r;       // Write waiting for its data phase
  reg  [7:0]  wr_addr_r;
  // Block state
  reg  [15:0] eff_level_r;     // Level in use this cycle
  reg         engaged_r;       // Stall prevention acting
  reg  [22:0] tick_cnt_r;      // 100 ms divider
  reg         tick_r;          // One-cycle tick enable
  reg  [15:0] delay_cnt_r;     // Ticks since engage
  reg  [1:0]  hold_cnt_r;      // Ticks since flag raised
  reg  [5:0]  low_cnt_r;       // Ticks at 1 Hz
  reg         clr_req_r;       // Fault clear strobe

  integer     i, j, k;   // One loop index per process

  ////////////////////////////////////////////////////////////////////
  // Level calculation and selection
  wire        sec_sel;
  wire [15:0] base_level;
  reg  signed [47:0] lvl_calc;
  reg  signed [47:0] a_v;
  reg  signed [47:0] b_v;
  reg  signed [47:0] den;
  reg  [15:0] lvl_nxt;

  // Any input terminal with the second-set code that is on
  reg sec_any;
  always @*
  begin
    sec_any = 1'b0;
    for (i = 0; i < N_IN; i = i + 1)
      if (infunc_r[i] == `SPC_FUNC_SECOND && in_term[i])
        sec_any = 1'b1; // RL11
  end
  assign sec_sel = sec_any;

  // Second level replaces the first unless it reads "same as first"
  assign base_level = (sec_sel && level2_r != `SPC_NOT_USED) ? level2_r
                                                              : level_r; // RL10

  // High-frequency reduction, clamped at zero
  always @*
  begin
    a_v      = 48'sd0;
    b_v      = 48'sd0;
    den      = 48'sd0;
    lvl_calc = 48'sd0;
    lvl_nxt  = base_level;
    if (hsfact_r != `SPC_NOT_USED && redfreq_r != 16'h0000 &&
        out_freq > redfreq_r) // RL8
    begin
      a_v = $signed({16'h0000, redfreq_r} * {16'h0000, base_level})
            / $signed({32'h0, out_freq}); // RL7
      b_v = $signed({16'h0000, redfreq_r} * {16'h0000, base_level})
            / $signed({32'h0, `SPC_FREQ_400HZ});
      den = ($signed({32'h0, base_level}) - b_v) * 48'sd100;
      if (den != 48'sd0)
      begin
        lvl_calc = a_v + (b_v * ($signed({32'h0, base_level}) - a_v)
                   * ($signed({32'h0, hsfact_r}) - 48'sd100)) / den; // RL7
        if (lvl_calc < 48'sd0)
          lvl_nxt = 16'h0000;
        else if (lvl_calc > 48'sd65535)
          lvl_nxt = 16'hFFFF;
        else
          lvl_nxt = lvl_calc[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Engage decision per phase
  wire [4:0] mode_bits = mode_dec(mode_r, regen);
  reg        phase_en;
  always @*
  begin
    case (drive_phase)
      `SPC_PH_ACCEL: phase_en = ~mode_bits[1];
      `SPC_PH_CONST: phase_en = ~mode_bits[2];
      `SPC_PH_DECEL: phase_en = ~mode_bits[3];
      default:       phase_en = 1'b0;
    endcase
  end

  // Zero level means the function is off; disabled phase gives nothing
  wire engage_nxt = phase_en && eff_level_r != 16'h0000 &&
                    out_current > eff_level_r; // RL1 RL17

  // Flag would be due now (delay elapsed, not suppressed)
  wire flag_due = engaged_r && delay_r != `SPC_NOT_USED &&
                  delay_cnt_r >= delay_r; // RL4
  wire hold_done = hold_cnt_r >= `SPC_HOLD_TICKS;

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite address decode
  wire       acc_ok = hsel && hready && htrans[1];
  reg [31:0] rd_nxt;
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (haddr)
      `SPC_OFS_LEVEL:   rd_nxt = {16'h0000, level_r};
      `SPC_OFS_HSFACT:  rd_nxt = {16'h0000, hsfact_r};
      `SPC_OFS_REDFREQ: rd_nxt = {16'h0000, redfreq_r};
      `SPC_OFS_LEVEL2:  rd_nxt = {16'h0000, level2_r};
      `SPC_OFS_MODE:    rd_nxt = {24'h000000, mode_r};
      `SPC_OFS_DELAY:   rd_nxt = {16'h0000, delay_r};
      `SPC_OFS_STATUS:  rd_nxt = {eff_level_r, 8'h00, 1'b0, second_set_select,
                                  fast_limit_off, output_shutoff,
                                  stall_stop_fault, stall_frequency_trip,
                                  stall_active_flag, engaged_r};
      default:
      begin
        // Terminal function tables, unmapped reads as zero
        for (j = 0; j < N_IN; j = j + 1)
          if (haddr == `SPC_OFS_INFUNC + j[5:0] * 4)
            rd_nxt = {24'h000000, infunc_r[j]};
        for (j = 0; j < N_OUT; j = j + 1)
          if (haddr == `SPC_OFS_OUTFUNC + j[5:0] * 4)
            rd_nxt = {24'h000000, outfunc_r[j]};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Bus slave and register writes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      level_r   <= `SPC_RST_LEVEL;
      hsfact_r  <= `SPC_RST_HSFACT;
      redfreq_r <= `SPC_RST_REDFREQ;
      level2_r  <= `SPC_RST_LEVEL2;
      mode_r    <= `SPC_RST_MODE;
      delay_r   <= `SPC_RST_DELAY;
      clr_req_r <= 1'b0;
      for (k = 0; k < N_IN; k = k + 1)
        infunc_r[k] <= 8'h00;
      for (k = 0; k < N_OUT; k = k + 1)
        outfunc_r[k] <= 8'h00;
    end
    else
    begin
      // Zero wait states, always OKAY
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      clr_req_r <= 1'b0;
      if (hready)
      begin
        wr_pend_r <= acc_ok && hwrite;
        wr_addr_r <= haddr;
      end
      // Read data sampled in address phase, shown in data phase
      if (acc_ok && !hwrite)
        hrdata <= rd_nxt;
      // Write data arrives one cycle after its address
      if (wr_pend_r)
      begin
        case (wr_addr_r)
          `SPC_OFS_LEVEL:   level_r   <= hwdata[15:0];
          `SPC_OFS_HSFACT:  hsfact_r  <= hwdata[15:0];
          `SPC_OFS_REDFREQ: redfreq_r <= hwdata[15:0];
          `SPC_OFS_LEVEL2:  level2_r  <= hwdata[15:0];
          `SPC_OFS_MODE:    mode_r    <= hwdata[7:0];
          `SPC_OFS_DELAY:   delay_r   <= hwdata[15:0];
          `SPC_OFS_CLEAR:   clr_req_r <= hwdata[0];
          default:
          begin
            for (k = 0; k < N_IN; k = k + 1)
              if (wr_addr_r == `SPC_OFS_INFUNC + k[5:0] * 4)
                infunc_r[k] <= hwdata[7:0];
            for (k = 0; k < N_OUT; k = k + 1)
              if (wr_addr_r == `SPC_OFS_OUTFUNC + k[5:0] * 4)
                outfunc_r[k] <= hwdata[7:0];
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // 100 ms tick divider
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_r <= 23'h000000;
      tick_r     <= 1'b0;
    end
    else if (tick_cnt_r == TICK_CYC[22:0] - 23'h000001)
    begin
      tick_cnt_r <= 23'h000000;
      tick_r     <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 23'h000001;
      tick_r     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stall engine: level, steering, flag timing, trips
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      eff_level_r          <= `SPC_RST_LEVEL;
      engaged_r            <= 1'b0;
      freq_cmd             <= `SPC_FC_NONE;
      delay_cnt_r          <= 16'h0000;
      hold_cnt_r           <= 2'h0;
      low_cnt_r            <= 6'h00;
      stall_active_flag    <= 1'b0;
      stall_frequency_trip <= 1'b0;
      stall_stop_fault     <= 1'b0;
      fast_limit_off       <= 1'b0;
      output_shutoff       <= 1'b0;
      second_set_select    <= 1'b0;
    end
    else
    begin
      eff_level_r       <= lvl_nxt;
      second_set_select <= sec_sel; // RL12
      // Trips stop the engine
      engaged_r <= engage_nxt && !output_shutoff;
      // Frequency steering while engaged
      if (engage_nxt && !output_shutoff)
      begin
        if (drive_phase == `SPC_PH_DECEL)
          freq_cmd <= `SPC_FC_RAISE; // RL2
        else
          freq_cmd <= `SPC_FC_LOWER; // RL2
      end
      else
        freq_cmd <= `SPC_FC_NONE;
      // Delay timer counts from engage, clears on recovery
      if (!engaged_r)
        delay_cnt_r <= 16'h0000; // RL18
      else if (tick_r && delay_cnt_r != 16'hFFFF)
        delay_cnt_r <= delay_cnt_r + 16'h0001;
      // Flag: only stall activity raises it, min hold two ticks
      if (flag_due && !stall_active_flag)
      begin
        stall_active_flag <= 1'b1; // RL3 RL16
        hold_cnt_r        <= 2'h0;
      end
      else if (stall_active_flag)
      begin
        if (tick_r && !hold_done)
          hold_cnt_r <= hold_cnt_r + 2'h1;
        if (!engaged_r && hold_done)
          stall_active_flag <= 1'b0; // RL3
      end
      // Time spent at or below 1 Hz while engaged
      if (!engaged_r || out_freq > `SPC_FREQ_1HZ)
        low_cnt_r <= 6'h00;
      else if (tick_r && low_cnt_r != 6'h3F)
        low_cnt_r <= low_cnt_r + 6'h01;
      // Sticky faults; a new cause wins over a clear
      if (low_cnt_r >= `SPC_TRIP_TICKS)
        stall_frequency_trip <= 1'b1; // RL6
      else if (clr_req_r)
        stall_frequency_trip <= 1'b0;
      if (flag_due && mode_bits[4])
        stall_stop_fault <= 1'b1; // RL14
      else if (clr_req_r)
        stall_stop_fault <= 1'b0;
      // Fast-response limit shuts off for the over-current cycle
      fast_limit_off <= fast_over && !mode_bits[0]; // RL13
      output_shutoff <= stall_frequency_trip || stall_stop_fault ||
                        (fast_over && !mode_bits[0]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output terminal routing
  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1)
    begin : g_out
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          out_term[g] <= 1'b0;
        else if (outfunc_r[g] == `SPC_FUNC_FLAG_POS)
          out_term[g] <= stall_active_flag; // RL5
        else if (outfunc_r[g] == `SPC_FUNC_FLAG_NEG)
          out_term[g] <= ~stall_active_flag; // RL5
        else
          out_term[g] <= 1'b0;
      end
    end
  endgenerate

endmodule // spc_stall_ctrl

// File: sim/spc_stall_ctrl_monitor.sv
// Checker for the stall prevention control block.
// Sees only top-level ports; bound from the bench top.
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_stall_monitor #(
  parameter TICK_CYC = 20,
  parameter N_IN     = 5
) (
  // Clock and reset
  input wire            hclk,
  input wire            hresetn,
  // Bus answer
  input wire            hreadyout,
  input wire            hresp,
  // Drive side
  input wire [15:0]     out_freq,
  input wire [1:0]      drive_phase,
  input wire            fast_over,
  input wire [N_IN-1:0] in_term,
  input wire [1:0]      freq_cmd,
  input wire            stall_active_flag,
  input wire            stall_frequency_trip,
  input wire            fast_limit_off,
  input wire            output_shutoff,
  input wire            second_set_select
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  reg [15:0] hi_cnt_r; // Cycles the flag has stood
  reg [15:0] lo_cnt_r; // Cycles spent at or below 1 Hz
  // Run lengths, cleared when the condition breaks
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hi_cnt_r <= 16'h0000;
      lo_cnt_r <= 16'h0000;
    end
    else
    begin
      hi_cnt_r <= stall_active_flag ? hi_cnt_r + 16'h0001 : 16'h0000;
      lo_cnt_r <= (out_freq <= `SPC_FREQ_1HZ) ? lo_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_raise; freq_cmd == `SPC_FC_RAISE |-> $past(drive_phase) == `SPC_PH_DECEL; endproperty
  a_raise: assert property (p_raise) else $error("raise outside deceleration");
  property p_lower;
    freq_cmd == `SPC_FC_LOWER |-> $past(drive_phase) inside {`SPC_PH_CONST, `SPC_PH_ACCEL};
  endproperty
  a_lower: assert property (p_lower) else $error("lower outside accel or constant");
  property p_idle; drive_phase == 2'h3 [*3] |-> freq_cmd == `SPC_FC_NONE; endproperty
  a_idle: assert property (p_idle) else $error("steering while stopped");
  property p_hold; $fell(stall_active_flag) |-> hi_cnt_r > TICK_CYC; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped too soon");
  property p_trip_shut; $rose(stall_frequency_trip) |=> output_shutoff; endproperty
  a_trip_shut: assert property (p_trip_shut) else $error("trip without shutoff");
  property p_trip_time; $rose(stall_frequency_trip) |-> lo_cnt_r >= 29 * TICK_CYC; endproperty
  a_trip_time: assert property (p_trip_time) else $error("trip before 3 s at 1 Hz");
  property p_fast; fast_limit_off |-> $past(fast_over); endproperty
  a_fast: assert property (p_fast) else $error("fast limit without comparator");
  property p_second; in_term == 0 |=> !second_set_select; endproperty
  a_second: assert property (p_second) else $error("second set with no input");
  // Main scenarios reached
  c_flag: cover property ($rose(stall_active_flag));
  c_trip: cover property ($rose(stall_frequency_trip));
  c_raise: cover property (freq_cmd == `SPC_FC_RAISE);
endmodule // spc_stall_monitor

// File: sim/spc_drive_model.sv
// Behavioural motor load: frequency follows the steering command.
// Current is set by the bench; a shutoff drops both to zero.
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_drive_model (
  // Clock and reset
  input wire         hclk,
  input wire         hresetn,
  // From the control block
  input wire [1:0]   freq_cmd,
  input wire         output_shutoff,
  // Bench settings
  input wire         freq_load,
  input wire [15:0]  freq_val,
  input wire [15:0]  cur_set,
  // Measurements
  output reg  [15:0] out_freq,
  output wire [15:0] out_current
);
  // No current flows once the output is cut
  assign out_current = output_shutoff ? 16'h0000 : cur_set;
  // Ramp 0.5 Hz a cycle, floor at 1 Hz when lowered
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_freq <= 16'h0000;
    else if (output_shutoff)
      out_freq <= 16'h0000;
    else if (freq_load)
      out_freq <= freq_val;
    else if (freq_cmd == `SPC_FC_LOWER)
      out_freq <= (out_freq > 16'h0096) ? out_freq - 16'h0032 : `SPC_FREQ_1HZ;
    else if (freq_cmd == `SPC_FC_RAISE)
      out_freq <= out_freq + 16'h0032;
  end
endmodule // spc_drive_model

// File: sim/test_spc_stall_ctrl.sv
// Self-checking bench for the stall prevention control block.
// Acts as AHB-Lite master; drive inputs come from the bench and a load model.
`timescale 1ns/1ps
`include "spc_consts.vh"
module test_spc_stall_ctrl;
  localparam TK = 20; // Short tick keeps the run brief
  localparam [55:0]  RA = {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h3C};
  localparam [111:0] RV = {16'h05DC, 16'h270F, 16'h1770, 16'h270F, 48'h0};
  localparam [49:0]  FT = {10'h001, 10'h004, 10'h191, 10'h194, 10'h197};
  reg         hclk, hresetn, hsel, hwrite, regen, fast_over, freq_load;
  reg  [7:0]  haddr;
  reg  [1:0]  htrans, drive_phase;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata, rd;
  reg  [4:0]  in_term;
  reg  [15:0] freq_val, cur_set;
  wire        hready, hresp, flag, trip, stopf, foff, shut, sec;
  wire [31:0] hrdata;
  wire [2:0]  out_term;
  wire [1:0]  freq_cmd;
  wire [15:0] out_freq, out_current;
  integer     error_cnt, cmp_count, i;
  spc_stall_ctrl #(.TICK_CYC(TK)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .out_current(out_current), .out_freq(out_freq), .drive_phase(drive_phase),
    .regen(regen), .fast_over(fast_over), .in_term(in_term), .out_term(out_term),
    .freq_cmd(freq_cmd), .stall_active_flag(flag), .stall_frequency_trip(trip),
    .stall_stop_fault(stopf), .fast_limit_off(foff), .output_shutoff(shut),
    .second_set_select(sec));
  spc_drive_model u_load (.hclk(hclk), .hresetn(hresetn), .freq_cmd(freq_cmd),
    .output_shutoff(shut), .freq_load(freq_load), .freq_val(freq_val),
    .cur_set(cur_set), .out_freq(out_freq), .out_current(out_current));
  always #25 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input integer n); repeat (n) @(posedge hclk); endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %0s exp %0h got %0h", nm, e, g);
    end
  end
  endtask
  // Single word transfer; waits on hready in both phases
  task ahb(input w, input [7:0] a, input [31:0] d);
  begin
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  end
  endtask
  task drv(input [1:0] p, input [15:0] c);
  begin
    drive_phase <= p;
    cur_set     <= c;
  end
  endtask
  task fload(input [15:0] f);
  begin
    freq_load <= 1'b1;
    freq_val  <= f;
    cyc(1);
    freq_load <= 1'b0;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
  begin
    ahb(1, 8'h3C, 32'hFFFF);
    for (i = 0; i < 7; i = i + 1)
    begin
      ahb(0, RA[i*8 +: 8], 0);
      chk("reg", RV[i*16 +: 16], rd);
    end
  end
  endtask
  task t_engage;
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      drv(i[1:0], 16'h05DD);
      cyc(4);
      chk("freq_cmd", (i == 2) ? `SPC_FC_RAISE : `SPC_FC_LOWER, freq_cmd);
      chk("flag", 1, flag);
      chk("term_pos", 1, out_term[0]);
      chk("term_neg", 0, out_term[1]);
      drv(i[1:0], 16'h05DC);
      cyc(3);
      chk("flag_hold", 1, flag);
      chk("cmd_idle", `SPC_FC_NONE, freq_cmd);
      cyc(2 * TK + 2);
      chk("flag_off", 0, flag);
      chk("term_neg", 1, out_term[1]);
    end
  end
  endtask
  task t_delay;
  begin
    ahb(1, `SPC_OFS_DELAY, 32'h2);
    drv(`SPC_PH_ACCEL, 16'h05DD);
    cyc(TK / 2);
    drv(`SPC_PH_ACCEL, 16'h0000);
    cyc(3 * TK);
    chk("brief", 0, flag);
    drv(`SPC_PH_ACCEL, 16'h05DD);
    cyc(3);
    chk("early", 0, flag);
    cyc(3 * TK);
    chk("late", 1, flag);
    ahb(1, `SPC_OFS_DELAY, 32'h270F);
    drv(`SPC_PH_ACCEL, 16'h0000);
    cyc(2 * TK + 2);
    drv(`SPC_PH_ACCEL, 16'h05DD);
    cyc(4 * TK);
    chk("never", 0, flag);
    drv(`SPC_PH_ACCEL, 16'h0000);
    ahb(1, `SPC_OFS_DELAY, 32'h0);
  end
  endtask
  task t_second;
  begin
    ahb(1, `SPC_OFS_LEVEL2, 32'h3E8);
    ahb(1, `SPC_OFS_INFUNC + 8'h08, 32'h3);
    drv(`SPC_PH_ACCEL, 16'h04B0);
    cyc(4);
    chk("first_lvl", 0, flag);
    in_term <= 5'h04;
    cyc(6);
    chk("sec", 1, sec);
    chk("second_lvl", 1, flag);
    in_term <= 5'h02;
    drv(`SPC_PH_ACCEL, 16'h0000);
    cyc(2 * TK + 4);
    chk("sec_off", 0, sec);
  end
  endtask
  task t_mode;
  begin
    ahb(1, `SPC_OFS_MODE, 32'h4);
    drv(`SPC_PH_CONST, 16'h05DD);
    cyc(4);
    chk("const_off", `SPC_FC_NONE, freq_cmd);
    chk("const_flag", 0, flag);
    ahb(1, `SPC_OFS_MODE, 32'hE);
    for (i = 0; i < 3; i = i + 1)
    begin
      drv(i[1:0], 16'h05DD);
      cyc(4);
      chk("all_off", 0, flag | trip);
    end
    ahb(1, `SPC_OFS_MODE, 32'h10);
    drv(`SPC_PH_CONST, 16'h05DD);
    cyc(3);
    chk("stop", 1, stopf);
    drv(`SPC_PH_CONST, 16'h0000);
    ahb(1, `SPC_OFS_CLEAR, 32'h1);
    cyc(2 * TK + 2);
    chk("stop_clr", 0, stopf);
    for (i = 0; i < 5; i = i + 1)
    begin
      ahb(1, `SPC_OFS_MODE, {24'h0, FT[i*10+2 +: 8]});
      regen     <= FT[i*10+1];
      fast_over <= 1'b1;
      cyc(3);
      chk("fast_off", FT[i*10], foff);
      chk("fast_flag", 0, flag);
      fast_over <= 1'b0;
      ahb(1, `SPC_OFS_CLEAR, 32'h1);
    end
    ahb(1, `SPC_OFS_MODE, 32'h0);
  end
  endtask
  task t_trip;
  begin
    fload(16'h07D0);
    drv(`SPC_PH_CONST, 16'h05DD);
    cyc(28 * TK);
    chk("trip_early", 0, trip);
    i = 0;
    while (trip !== 1'b1 && i < 5 * TK)
    begin
      cyc(1);
      i = i + 1;
    end
    cyc(2);
    chk("trip", 1, trip);
    chk("shut", 1, shut);
    drv(`SPC_PH_CONST, 16'h0000);
    ahb(1, `SPC_OFS_CLEAR, 32'h1);
    cyc(2);
    chk("trip_clr", 0, trip);
  end
  endtask
  task t_reduce;
  begin
    drv(2'h3, 16'h0000);
    fload(16'h2EE0);
    ahb(1, `SPC_OFS_HSFACT, 32'h64);
    cyc(3);
    ahb(0, `SPC_OFS_STATUS, 0);
    chk("reduced", 16'h02EE, rd[31:16]);
    fload(16'h9C40);
    ahb(1, `SPC_OFS_HSFACT, 32'h270F);
    cyc(3);
    ahb(0, `SPC_OFS_STATUS, 0);
    chk("constant", 16'h05DC, rd[31:16]);
  end
  endtask
  task end_sim;
  begin
    $display("Errors %0d of %0d checks", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {error_cnt, cmp_count, hclk, hresetn, haddr, htrans, hwrite, hwdata} = 0;
    {drive_phase, regen, fast_over, in_term, freq_load, freq_val, cur_set} = 0;
    hsel  = 1'b1;
    hsize = 3'h2;
    cyc(20);
    hresetn <= 1'b1;
    cyc(1);
    t_regs;
    ahb(1, `SPC_OFS_OUTFUNC, 32'h3);
    ahb(1, `SPC_OFS_OUTFUNC + 8'h04, 32'h67);
    fload(16'h0BB8);
    t_engage;
    t_delay;
    t_second;
    t_mode;
    t_trip;
    t_reduce;
    end_sim;
  end
  // Hang guard, far beyond the expected run
  initial
  begin
    #2000000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
endmodule // test_spc_stall_ctrl
bind spc_stall_ctrl spc_stall_monitor #(.TICK_CYC(TICK_CYC), .N_IN(N_IN)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .out_freq(out_freq), .drive_phase(drive_phase), .fast_over(fast_over),
  .in_term(in_term), .freq_cmd(freq_cmd), .stall_active_flag(stall_active_flag),
  .stall_frequency_trip(stall_frequency_trip), .fast_limit_off(fast_limit_off),
  .output_shutoff(output_shutoff), .second_set_select(second_set_select));
